// >>> src/dtc_pkg.sv
/*
 * Shared constants for the data transfer controller: transfer information
 * layout, mode and size codes, vector table geometry and the state type.
 * Assumes a 32-bit byte-addressed system bus with word-aligned info sets.
 */
package dtc_pkg;

	// ------------------------------------------------------------------
	// Transfer information geometry
	// ------------------------------------------------------------------
	localparam int VEC_ALIGN_BITS = 10;
	localparam logic [31:0] INFO_SET_BYTES = 32'h0000_0010;
	localparam logic [1:0] INFO_LAST_WORD = 2'h3;

	// Fields of info word 0
	localparam int F_MODE = 30;
	localparam int F_SIZE = 28;
	localparam int F_CHAIN = 27;
	localparam int F_IRQ_EACH = 26;
	localparam int F_RPT_DST = 25;
	localparam int F_WB_SKIP = 24;
	localparam int F_SRC_AM = 22;
	localparam int F_DST_AM = 20;
	localparam int F_IRQ_END = 19;

	// ------------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------------
	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_REPEAT = 2'h1;
	localparam logic [1:0] MODE_BLOCK = 2'h2;
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] AM_FIXED = 2'h0;
	localparam logic [1:0] AM_INC = 2'h1;
	localparam logic [1:0] AM_DEC = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_VREAD = 3'h1,
		ST_IREAD = 3'h2,
		ST_XREAD = 3'h3,
		ST_XWRITE = 3'h4,
		ST_WBACK = 3'h5,
		ST_FIN = 3'h6
	} dtc_state_t;

	// An 8-bit count field of zero stands for 256
	function automatic logic [8:0] dtc_count8(input logic [7:0] c);
		dtc_count8 = (c == 8'h00) ? 9'h100 : {1'b0, c};
	endfunction : dtc_count8

endpackage : dtc_pkg

// >>> src/dtc_addr_step.sv
/*
 * Address stepper: moves an address by a number of units of the given
 * size in the direction of the address mode, or backwards when undo is set.
 * Purely combinational; used for both per-unit steps and area restores.
 */
`timescale 1ns/1ps
`default_nettype none
module dtc_addr_step
	import dtc_pkg::*;
(
	input wire logic [31:0] addr,
	input wire logic [1:0] am,
	input wire logic [1:0] size,
	input wire logic [8:0] units,
	input wire logic undo,
	output logic [31:0] res
);
	// ------------------------------------------------------------------
	// Offset and direction
	// ------------------------------------------------------------------
	wire [31:0] offset = {23'h0, units} << size;
	wire moving = (am == AM_INC) || (am == AM_DEC);
	wire up = (am == AM_INC) ^ undo;

	assign res = !moving ? addr : (up ? addr + offset : addr - offset);
endmodule : dtc_addr_step
`default_nettype wire

// >>> src/dtc_top.sv
/*
 * Data transfer controller core: vector fetch, info read, unit moves,
 * repeat/block restore, write-back, chaining and CPU interrupt pulse.
 * Assumes a bus fabric that holds each request until one-cycle bus_ack and
 * presents narrow read data right-aligned in bus_rdata.
 */
// Function
// - Info located in RAM via vector entry
// - Separate info set per source vector
// - CPU interrupt request may start transfer
// - Move between memory, peripheral, external spaces
// - Normal units are byte, halfword, word
// - Block size one unit to 256 longwords
// - Normal count 1 through 65536
// - Repeat count 1-256, then restart
// - Block count 1 through 65536
// - Optional interrupt per unit transfer end
// - Optional interrupt after counted transfers
// - Optional skipping of info read
// - Module stop halts operation
// - Vector address is base plus four times
`timescale 1ns/1ps
`default_nettype none
module dtc_top
	import dtc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic act_req,
	input wire logic [7:0] act_vec,
	input wire logic [1:0] act_src,
	input wire logic module_stop,
	input wire logic module_start_ctl,
	input wire logic skip_read_en,
	input wire logic [31:0] vector_base_addr,
	input wire logic bus_ack,
	input wire logic [31:0] bus_rdata,
	output logic act_ack,
	output logic busy,
	output logic cpu_irq,
	output logic bus_req,
	output logic bus_we,
	output logic [1:0] bus_size,
	output logic [31:0] bus_addr,
	output logic [31:0] bus_wdata
);
	// ------------------------------------------------------------------
	// State and cached transfer information
	// ------------------------------------------------------------------
	dtc_state_t state;
	logic [1:0] widx;
	logic [7:0] vec;
	logic [31:0] info_addr;
	logic [31:0] mode_w;
	logic [31:0] sar;
	logic [31:0] dar;
	logic [15:0] crb;
	logic [31:0] dbuf;
	logic [8:0] blk_left;
	logic end_hit;
	logic cache_vld;
	logic [7:0] cache_vec;
	logic chained;

	// Field views of info word 0
	wire [1:0] mode = mode_w[F_MODE +: 2];
	wire [1:0] usize = mode_w[F_SIZE +: 2];
	wire chain = mode_w[F_CHAIN];
	wire irq_each = mode_w[F_IRQ_EACH];
	wire rpt_dst = mode_w[F_RPT_DST];
	wire wb_skip = mode_w[F_WB_SKIP];
	wire [1:0] src_am = mode_w[F_SRC_AM +: 2];
	wire [1:0] dst_am = mode_w[F_DST_AM +: 2];
	wire irq_end = mode_w[F_IRQ_END];
	wire [15:0] cra = mode_w[15:0];

	// Entry address: aligned base plus four bytes per vector
	wire [31:0] vec_addr = {vector_base_addr[31:VEC_ALIGN_BITS],
		{VEC_ALIGN_BITS{1'b0}}} + {22'h0, vec, 2'h0};

	// Sources 0 to 2 are accepted alike and source code 3 is refused; the interrupt controller
	// already filtered by its enable bits, so beyond module start and module stop there is no other gate here.
	wire src_known = (act_src != 2'h3);
	wire can_start = act_req && src_known && module_start_ctl
		&& !module_stop;
	wire hit = skip_read_en && cache_vld && (cache_vec == act_vec);

	// ------------------------------------------------------------------
	// Address arithmetic: unit step, then restore of the repeat side
	// ------------------------------------------------------------------
	wire [31:0] src_step;
	wire [31:0] dst_step;
	wire [31:0] src_rest;
	wire [31:0] dst_rest;
	wire [8:0] rest_units = (mode == MODE_BLOCK) ? dtc_count8(cra[7:0])
		: dtc_count8(cra[15:8]);

	dtc_addr_step u_src_step (
		.addr(sar), .am(src_am), .size(usize), .units(9'h001),
		.undo(1'b0), .res(src_step)
	);
	dtc_addr_step u_dst_step (
		.addr(dar), .am(dst_am), .size(usize), .units(9'h001),
		.undo(1'b0), .res(dst_step)
	);
	dtc_addr_step u_src_rest (
		.addr(src_step), .am(src_am), .size(usize), .units(rest_units),
		.undo(1'b1), .res(src_rest)
	);
	dtc_addr_step u_dst_rest (
		.addr(dst_step), .am(dst_am), .size(usize), .units(rest_units),
		.undo(1'b1), .res(dst_rest)
	);

	// ------------------------------------------------------------------
	// Next bus request per state
	// ------------------------------------------------------------------
	wire in_bus = (state == ST_VREAD) || (state == ST_IREAD)
		|| (state == ST_XREAD) || (state == ST_XWRITE)
		|| (state == ST_WBACK);
	wire [31:0] info_word_addr = info_addr + {28'h0, widx, 2'h0};
	wire [31:0] wb_word = (widx == 2'h0) ? mode_w :
		(widx == 2'h1) ? sar :
		(widx == 2'h2) ? dar : {16'h0, crb};
	wire [31:0] req_addr = (state == ST_VREAD) ? vec_addr :
		(state == ST_XREAD) ? sar :
		(state == ST_XWRITE) ? dar : info_word_addr;
	wire req_we = (state == ST_XWRITE) || (state == ST_WBACK);
	wire [1:0] req_size = ((state == ST_XREAD) || (state == ST_XWRITE))
		? usize : SZ_WORD;
	wire [31:0] req_data = (state == ST_WBACK) ? wb_word : dbuf;
	// A stop request lets the current access finish but starts no new one
	wire issue = in_bus && !bus_req && !module_stop;
	wire done = bus_req && bus_ack;
	wire blk_more = (mode == MODE_BLOCK) && (blk_left != 9'h001);

	// ------------------------------------------------------------------
	// Bus master outputs
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bus_req <= 1'b0;
			bus_we <= 1'b0;
			bus_size <= SZ_WORD;
			bus_addr <= 32'h0;
			bus_wdata <= 32'h0;
		end
		else if (issue)
		begin
			bus_req <= 1'b1;
			bus_we <= req_we;
			bus_size <= req_size;
			bus_addr <= req_addr;
			bus_wdata <= req_data;
		end
		else if (done)
			bus_req <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= ST_IDLE;
			widx <= 2'h0;
			vec <= 8'h0;
			info_addr <= 32'h0;
			mode_w <= 32'h0;
			sar <= 32'h0;
			dar <= 32'h0;
			crb <= 16'h0;
			dbuf <= 32'h0;
			blk_left <= 9'h0;
			end_hit <= 1'b0;
			cache_vld <= 1'b0;
			cache_vec <= 8'h0;
			chained <= 1'b0;
			act_ack <= 1'b0;
			busy <= 1'b0;
			cpu_irq <= 1'b0;
		end
		else
		begin
			act_ack <= 1'b0;
			cpu_irq <= 1'b0;
			case (state)
			ST_IDLE:
				if (can_start)
				begin
					act_ack <= 1'b1;
					busy <= 1'b1;
					vec <= act_vec;
					chained <= 1'b0;
					blk_left <= dtc_count8(cra[7:0]);
					state <= hit ? ST_XREAD : ST_VREAD;
				end
			ST_VREAD:
				if (done)
				begin
					info_addr <= bus_rdata;
					widx <= 2'h0;
					state <= ST_IREAD;
				end
			ST_IREAD:
				if (done)
				begin
					case (widx)
					2'h0: mode_w <= bus_rdata;
					2'h1: sar <= bus_rdata;
					2'h2: dar <= bus_rdata;
					default: crb <= bus_rdata[15:0];
					endcase
					widx <= widx + 2'h1;
					if (widx == INFO_LAST_WORD)
					begin
						// Chained sets are not cached: a later skip would
						// pick up the tail of the chain instead of its head.
						cache_vld <= !chain && !chained;
						cache_vec <= vec;
						blk_left <= dtc_count8(cra[7:0]);
						state <= ST_XREAD;
					end
				end
			ST_XREAD:
				if (done)
				begin
					dbuf <= bus_rdata;
					state <= ST_XWRITE;
				end
			ST_XWRITE:
				if (done)
				begin
					sar <= src_step;
					dar <= dst_step;
					end_hit <= 1'b0;
					case (mode)
					MODE_REPEAT:
						if (cra[7:0] == 8'h01)
						begin
							mode_w[7:0] <= cra[15:8];
							if (rpt_dst)
								dar <= dst_rest;
							else
								sar <= src_rest;
						end
						else
							mode_w[7:0] <= cra[7:0] - 8'h01;
					MODE_BLOCK:
						if (blk_more)
							blk_left <= blk_left - 9'h001;
						else
						begin
							crb <= crb - 16'h0001;
							end_hit <= (crb == 16'h0001);
							if (rpt_dst)
								dar <= dst_rest;
							else
								sar <= src_rest;
						end
					default:
					begin
						mode_w[15:0] <= cra - 16'h0001;
						end_hit <= (cra == 16'h0001);
					end
					endcase
					widx <= 2'h0;
					state <= blk_more ? ST_XREAD :
						(wb_skip ? ST_FIN : ST_WBACK);
				end
			ST_WBACK:
				if (done)
				begin
					widx <= widx + 2'h1;
					if (widx == INFO_LAST_WORD)
						state <= ST_FIN;
				end
			ST_FIN:
				if (chain)
				begin
					info_addr <= info_addr + INFO_SET_BYTES;
					chained <= 1'b1;
					widx <= 2'h0;
					state <= ST_IREAD;
				end
				else
				begin
					cpu_irq <= irq_each || (end_hit && irq_end);
					busy <= 1'b0;
					state <= ST_IDLE;
				end
			default:
				state <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	vec_entry_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		(state == ST_VREAD) && bus_req |->
			bus_addr == ({vector_base_addr[31:10], 10'h0} + {22'h0, vec, 2'h0}))
		else $error("vector entry address wrong");
	stop_hold_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		module_stop && !bus_req && in_bus |=> !bus_req)
		else $error("access issued while stopped");
	start_gate_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		(state == ST_IDLE) && !module_start_ctl |=> !act_ack && !busy)
		else $error("started without module start");
	irq_pulse_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		cpu_irq |-> $past(state) == ST_FIN && !busy ##1 !cpu_irq)
		else $error("interrupt not a single pulse at finish");
	req_hold_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_we))
		else $error("bus request dropped before ack");
	wb_skip_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		(state == ST_XWRITE) && done && wb_skip && !blk_more |=>
			state == ST_FIN)
		else $error("write-back not skipped");
	chain_next_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		(state == ST_FIN) && chain |=>
			state == ST_IREAD && info_addr == $past(info_addr) + 32'h10)
		else $error("chain did not advance");
	normal_dec_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		(state == ST_XWRITE) && done && (mode == MODE_NORMAL) |=>
			cra == $past(cra) - 16'h0001)
		else $error("normal count not decremented");
	unit_size_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		(state == ST_XREAD) && bus_req |-> bus_size == usize && !bus_we)
		else $error("unit read has wrong size");
endmodule : dtc_top
`default_nettype wire

// >>> sim/dtc_mem_model.sv
/*
 * Fabric and RAM model on the far side of the controller's bus port.
 * Assumes one requester that holds bus_req until it sees bus_ack.
 */
`timescale 1ns/1ps
`default_nettype none
module dtc_mem_model
(
	input wire logic clk,
	input wire logic bus_req,
	input wire logic bus_we,
	input wire logic [1:0] bus_size,
	input wire logic [31:0] bus_addr,
	input wire logic [31:0] bus_wdata,
	input wire logic [3:0] wait_cycles,
	output logic bus_ack,
	output logic [31:0] bus_rdata,
	output int n_rd
);
	logic [31:0] mem [int unsigned];
	logic [31:0] w;
	logic [3:0] cnt;
	int nb;

	// Quiet start before the first request
	initial
	begin
		bus_ack = 1'b0;
		bus_rdata = 32'h0;
		cnt = 4'h0;
		n_rd = 0;
	end

	// Ack after wait_cycles; read data toggles when not valid so that
	// a design sampling it late cannot get lucky
	always @(posedge clk)
	begin
		bus_ack <= 1'b0;
		bus_rdata <= ~bus_rdata;
		w = mem.exists(bus_addr >> 2) ? mem[bus_addr >> 2] : 32'h0;
		nb = 1 << bus_size;
		if (bus_req && !bus_ack && cnt < wait_cycles)
			cnt <= cnt + 4'h1;
		else if (bus_req && !bus_ack)
		begin
			cnt <= 4'h0;
			bus_ack <= 1'b1;
			if (bus_we)
			begin
				// Narrow data arrives right-aligned
				for (int i = 0; i < nb; i++)
					w[8 * (bus_addr[1:0] + i) +: 8] = bus_wdata[8 * i +: 8];
				mem[bus_addr >> 2] = w;
			end
			else
			begin
				n_rd <= n_rd + 1;
				bus_rdata <= (w >> (8 * bus_addr[1:0]))
					& 32'((64'h1 << (8 * nb)) - 64'h1);
			end
		end
	end
endmodule : dtc_mem_model
`default_nettype wire

// >>> sim/dtc_top_tb.sv
/*
 * Self-checking bench for the transfer controller with a RAM model.
 * Assumes vectors, info sets and data are preloaded into the model.
 */
`timescale 1ns/1ps
`default_nettype none
module dtc_top_tb
	import dtc_pkg::*;
;
	localparam logic [31:0] VB = 32'h0001_0000;
	logic clk = 0, rst_b = 0, act_req = 0, module_stop = 0;
	logic module_start_ctl = 1, skip_read_en = 0;
	logic act_ack, busy, cpu_irq, bus_req, bus_we, bus_ack;
	logic [7:0] act_vec = 8'h00;
	logic [1:0] act_src = 2'h0, bus_size;
	logic [3:0] wait_cycles = 4'h0;
	logic [31:0] bus_rdata, bus_addr, bus_wdata;
	int n_errors = 0, tests_run = 0, irqs, n_rd, r0;

	dtc_top DUT (.clk(clk), .rst_b(rst_b), .act_req(act_req),
		.act_vec(act_vec), .act_src(act_src), .module_stop(module_stop),
		.module_start_ctl(module_start_ctl), .skip_read_en(skip_read_en),
		.vector_base_addr(VB | 32'h2a4), .bus_ack(bus_ack),
		.bus_rdata(bus_rdata), .act_ack(act_ack), .busy(busy),
		.cpu_irq(cpu_irq), .bus_req(bus_req), .bus_we(bus_we),
		.bus_size(bus_size), .bus_addr(bus_addr), .bus_wdata(bus_wdata));
	dtc_mem_model u_mem (.clk(clk), .bus_req(bus_req), .bus_we(bus_we),
		.bus_size(bus_size), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.wait_cycles(wait_cycles), .bus_ack(bus_ack),
		.bus_rdata(bus_rdata), .n_rd(n_rd));

	// 20 MHz clock
	always #25 clk = ~clk;

	task automatic chk(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic finish_test;
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	// Word 0 of an info set; both address modes increment
	function automatic logic [31:0] mk(input logic [1:0] m, sz,
		input logic [3:0] f, input logic ie, input logic [15:0] c);
		mk = {m, sz, f, AM_INC, AM_INC, ie, 3'h0, c};
	endfunction : mk

	task automatic wr(input logic [31:0] a, d);
		u_mem.mem[a >> 2] = d;
	endtask : wr

	function automatic logic [31:0] rdm(input logic [31:0] a);
		rdm = u_mem.mem[a >> 2];
	endfunction : rdm

	// Vector entry plus one four-word info set
	task automatic put(input logic [7:0] v, input logic [31:0] ia, w0,
		sa, da, w3);
		wr(VB + 4 * v, ia);
		wr(ia, w0);
		wr(ia + 4, sa);
		wr(ia + 8, da);
		wr(ia + 12, w3);
	endtask : put

	// Raise a request, hold it until taken, count interrupt pulses
	task automatic act(input logic [7:0] v, input logic [1:0] s);
		int n;
		irqs = 0;
		n = 0;
		@(negedge clk);
		act_vec = v;
		act_src = s;
		act_req = 1'b1;
		while (act_ack !== 1'b1 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		act_req = 1'b0;
		chk("act_ack", 1, act_ack);
		do
		begin
			@(negedge clk);
			irqs += (cpu_irq === 1'b1);
			n++;
		end
		while (busy !== 1'b0 && n < 3000);
		repeat (3)
		begin
			@(negedge clk);
			irqs += (cpu_irq === 1'b1);
		end
		chk("busy", 0, busy);
	endtask : act

	task automatic t_normal;
		put(8'h21, 32'h1000, mk(MODE_NORMAL, SZ_WORD, 4'h0, 1, 16'h2),
			32'h2000, 32'h3000, 0);
		wr(32'h2000, 32'ha5a5_0001);
		wr(32'h2004, 32'ha5a5_0002);
		act(8'h21, 2'h0);
		chk("dst0", 32'ha5a5_0001, rdm(32'h3000));
		chk("irq_mid", 0, irqs);
		chk("wb_sar", 32'h2004, rdm(32'h1004));
		act(8'h21, 2'h0);
		chk("dst1", 32'ha5a5_0002, rdm(32'h3004));
		chk("irq_end", 1, irqs);
	endtask : t_normal

	task automatic t_sizes;
		logic [31:0] msk [3] = '{32'hff, 32'hffff, 32'hffff_ffff};
		wr(32'h2100, 32'h1122_3344);
		for (int i = 0; i < 3; i++)
		begin
			put(8'h10 + i, 32'h1100 + 16 * i,
				mk(i[1:0], i[1:0], 4'h4, 0, 16'h5) & 32'h3fff_ffff,
				32'h2100, 32'h3100 + 4 * i, 0);
			act(8'h10 + i, i[1:0]);
			chk("unit", 32'h1122_3344 & msk[i], rdm(32'h3100 + 4 * i));
			chk("irq_each", 1, irqs);
		end
	endtask : t_sizes

	task automatic t_repeat;
		put(8'h22, 32'h1200, mk(MODE_REPEAT, SZ_WORD, 4'h0, 0, 16'h0101),
			32'h2200, 32'h3200, 0);
		act(8'h22, 2'h1);
		chk("rpt_sar", 32'h2200, rdm(32'h1204));
		chk("rpt_cnt", 32'h0101, rdm(32'h1200) & 32'hffff);
		chk("rpt_dar", 32'h3204, rdm(32'h1208));
	endtask : t_repeat

	task automatic t_block;
		wr(32'h2304, 32'h0bad_cafe);
		put(8'h23, 32'h1300, mk(MODE_BLOCK, SZ_WORD, 4'h0, 1, 16'h2),
			32'h2300, 32'h3300, 32'h2);
		act(8'h23, 2'h2);
		chk("blk_unit", 32'h0bad_cafe, rdm(32'h3304));
		chk("blk_dar", 32'h3308, rdm(32'h1308));
		chk("blk_cnt", 1, rdm(32'h130c) & 32'hffff);
		chk("blk_irq", 0, irqs);
	endtask : t_block

	task automatic t_chain;
		wr(32'h2404, 32'h5a5a_0404);
		put(8'h30, 32'h1400, mk(MODE_NORMAL, SZ_WORD, 4'h9, 0, 16'h1),
			32'h2400, 32'h3400, 0);
		put(8'hff, 32'h1410, mk(MODE_NORMAL, SZ_WORD, 4'h0, 1, 16'h1),
			32'h2404, 32'h3404, 0);
		act(8'h30, 2'h0);
		chk("chain_dst", 32'h5a5a_0404, rdm(32'h3404));
		chk("wb_skip", 32'h2400, rdm(32'h1404));
		chk("chain_irq", 1, irqs);
	endtask : t_chain

	// Slow partner; the second activation must skip vector and info reads
	task automatic t_skip;
		wait_cycles = 4'h3;
		skip_read_en = 1'b1;
		put(8'h40, 32'h1500, mk(MODE_NORMAL, SZ_WORD, 4'h0, 0, 16'h3),
			32'h2500, 32'h3500, 0);
		wr(32'h2500, 32'h1234_5501);
		wr(32'h2504, 32'h1234_5502);
		r0 = n_rd;
		act(8'h40, 2'h0);
		chk("reads_full", 6, n_rd - r0);
		r0 = n_rd;
		act(8'h40, 2'h0);
		chk("reads_skip", 1, n_rd - r0);
		chk("skip_dst", 32'h1234_5502, rdm(32'h3504));
		skip_read_en = 1'b0;
		wait_cycles = 4'h0;
	endtask : t_skip

	// Stop raised after acceptance, before the vector read: nothing new starts until it is lifted,
	// and the interrupted activation still completes afterwards
	task automatic t_pause;
		int h;
		int n;
		h = 0;
		n = 0;
		put(8'h41, 32'h1600, mk(MODE_NORMAL, SZ_WORD, 4'h0, 0, 16'h1),
			32'h2600, 32'h3600, 0);
		wr(32'h2600, 32'h0f0f_2600);
		@(negedge clk);
		act_vec = 8'h41;
		act_src = 2'h0;
		act_req = 1'b1;
		@(negedge clk);
		act_req = 1'b0;
		module_stop = 1'b1;
		chk("pause_ack", 1, act_ack);
		repeat (10)
		begin
			@(negedge clk);
			h += (bus_req !== 1'b0 || busy !== 1'b1);
		end
		chk("paused", 0, h);
		module_stop = 1'b0;
		while (busy !== 1'b0 && n < 300)
		begin
			@(negedge clk);
			n++;
		end
		chk("pause_busy", 0, busy);
		chk("pause_dst", 32'h0f0f_2600, rdm(32'h3600));
	endtask : t_pause

	// Held request that must never be taken
	task automatic hold(output int h);
		h = 0;
		@(negedge clk);
		act_req = 1'b1;
		repeat (20)
		begin
			@(negedge clk);
			h += (act_ack !== 1'b0 || bus_req !== 1'b0);
		end
		act_req = 1'b0;
	endtask : hold

	task automatic t_stop;
		int h;
		module_stop = 1'b1;
		hold(h);
		chk("stopped", 0, h);
		module_stop = 1'b0;
		module_start_ctl = 1'b0;
		hold(h);
		chk("not_started", 0, h);
		module_start_ctl = 1'b1;
		act_src = 2'h3;
		hold(h);
		chk("bad_src", 0, h);
	endtask : t_stop

	// Main sequence
	initial
	begin
		repeat (20) @(negedge clk);
		chk("rst_size", 32'(SZ_WORD), 32'(bus_size));
		rst_b = 1'b1;
		t_normal();
		t_sizes();
		t_repeat();
		t_block();
		t_chain();
		t_skip();
		t_pause();
		t_stop();
		finish_test();
	end

	// Watchdog: far beyond the few hundred cycles the run needs
	initial
	begin
		#(50 * 20000);
		n_errors++;
		finish_test();
	end
endmodule : dtc_top_tb
`default_nettype wire
